// >>> pwc_powerdown_ctrl.sv
/*
 * power-down and wake-up control: control register over classic wishbone,
 * power-down sequencing, clock gating, wake-up delay and interrupt.
 * assumes wakeEvent, sleepRequest and regUnlocked come from logic on clk;
 * clock gating outputs drive glitch-free gate cells outside.
 */
// Chosen here: register access over Wishbone and the register offsets.
// Operation
// [RULE_01] power-down stops pll and system clock
// [RULE_02] low-speed-sourced peripheral clocks keep running
// [RULE_03] armed bit plus wfi enters power-down
// [RULE_04] wake event sets wake flag
// [RULE_05] write one clears wake flag
// [RULE_06] wake flag operative only when enabled
// [RULE_07] interrupt when flag and enable high
// [RULE_08] delay 4096, 256 or 512 clocks
// [RULE_09] delay inserted only when enabled
// [RULE_10] slow rc enable bit drives oscillator
// [RULE_11] fast rc enable bit drives oscillator
// [RULE_12] protected bits ignore writes while locked
// [RULE_13] arm bit auto-cleared on wake-up
// [RULE_14] power-down stops fast oscillators
// [RULE_15] delay counter gates clock release
`include "pwc_consts.svh"

module pwc_powerdown_ctrl #(
    parameter int PERIPH_COUNT = 4    // peripheral clocks under control
) (
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    // wishbone slave
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [3:0]              wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic      [31:0]             wb_dat_o,
    output logic                         wb_ack_o,
    output logic                         wb_err_o,
    // core and system side
    input  wire logic                    sleepRequest,
    input  wire logic                    wakeEvent,
    input  wire logic                    regUnlocked,
    input  wire logic [1:0]              sysClkSource,
    input  wire logic [PERIPH_COUNT-1:0] periphLowSpeedSrc,
    input  wire logic [PERIPH_COUNT-1:0] periphClkEnable,
    // clock and oscillator controls
    output logic                         sysClkRun,
    output logic                         pllRun,
    output logic [PERIPH_COUNT-1:0]      periphClkRun,
    output logic                         hsCrystalRun,
    output logic                         fastRcRun,
    output logic                         rc48Run,
    output logic                         slowRcRun,
    output logic                         inPowerDown,
    output logic                         wakeIrq,
    output logic                         irq
);

    // ************************************************************
    // elaboration checks
    // ************************************************************
    if (PERIPH_COUNT < 1 || PERIPH_COUNT > 32)
    begin : g_check
        $error("PERIPH_COUNT must be 1 to 32");
    end

    // ************************************************************
    // state
    // ************************************************************
    pwc_pkg::pwc_state_e state, next_state;             // power state
    logic [12:0]         delayCount, next_delayCount;   // remaining wake delay clocks
    logic                armBit, next_armBit;           // power-down armed
    logic                wakeFlag, next_wakeFlag;       // wake-up flag
    logic                wakeIen, next_wakeIen;         // wake interrupt enable
    logic                delayEn, next_delayEn;         // wake delay enable
    logic                slowRcEn, next_slowRcEn;       // slow rc enable
    logic                fastRcEn, next_fastRcEn;       // fast rc enable
    logic                rc48En, next_rc48En;           // 48 MHz rc enable
    logic [1:0]          irqStatus, next_irqStatus;     // sticky events: 0 wake, 1 pd entry
    logic [1:0]          irqMask, next_irqMask;         // 1 lets the event through
    logic                ack, next_ack;                 // bus answer
    logic [31:0]         rdData, next_rdData;           // registered read data
    logic                err, next_err;                 // unmapped address answer
    // reset word of the control register, picked apart bit by bit on reset
    localparam logic [31:0] RST_CTRL = `PWC_RST_CTRL;

    // bus strobes: one access per request, ack drops after one cycle
    logic        busReq, wrLow, ctrlWr, statWr, maskWr;   // decoded bus request
    logic        mapped, wakeNow;                         // address hit, wake while down
    logic [12:0] delayLoad;                               // hold-off for this source

    assign busReq = wb_cyc_i && wb_stb_i && !ack && !err;
    assign wrLow  = busReq && wb_we_i && wb_sel_i[0];
    assign mapped = (wb_adr_i == `PWC_OFS_CTRL) || (wb_adr_i == `PWC_OFS_STATUS)
                    || (wb_adr_i == `PWC_OFS_MASK);
    assign ctrlWr = wrLow && (wb_adr_i == `PWC_OFS_CTRL);
    assign statWr = wrLow && (wb_adr_i == `PWC_OFS_STATUS);
    assign maskWr = wrLow && (wb_adr_i == `PWC_OFS_MASK);
    // wake-up counts only while powered down
    assign wakeNow = (state == pwc_pkg::POWER_DOWN) && wakeEvent;

    // [RULE_08] delay by source
    always_comb
    begin
        unique case (pwc_pkg::pwc_src_e'(sysClkSource))
            pwc_pkg::SRC_HS_CRYSTAL: delayLoad = `PWC_DLY_HS_XTAL;
            pwc_pkg::SRC_FAST_RC:    delayLoad = `PWC_DLY_FAST_RC;
            pwc_pkg::SRC_RC48:       delayLoad = `PWC_DLY_RC48;
            default:                 delayLoad = 13'h0001;
        endcase
    end

    // ************************************************************
    // power sequencing next state
    // ************************************************************
    always_comb
    begin
        next_state      = state;
        next_delayCount = delayCount;
        unique case (state)
            pwc_pkg::RUN:
            begin
                // [RULE_03] enter on armed wfi
                if (armBit && sleepRequest)
                    next_state = pwc_pkg::POWER_DOWN;
            end
            pwc_pkg::POWER_DOWN:
            begin
                // [RULE_15] load counter on wake
                next_delayCount = delayLoad;   // reloaded while asleep, only read after wake
                // [RULE_09] delay only if enabled
                if (wakeEvent && delayEn)
                    next_state = pwc_pkg::WAKE_DELAY;
                else if (wakeEvent)
                    next_state = pwc_pkg::RUN;
            end
            pwc_pkg::WAKE_DELAY:
            begin
                // [RULE_15] release at terminal count
                next_delayCount = delayCount - 13'h0001;
                if (delayCount == 13'h0001)
                    next_state = pwc_pkg::RUN;
            end
            // the unused fourth code falls back to run
            default: next_state = pwc_pkg::RUN;
        endcase
    end

    // ************************************************************
    // control register next values
    // ************************************************************
    always_comb
    begin
        next_armBit    = armBit;
        next_wakeIen   = wakeIen;
        next_delayEn   = delayEn;
        next_slowRcEn  = slowRcEn;
        next_fastRcEn  = fastRcEn;
        next_rc48En    = rc48En;
        next_wakeFlag  = wakeFlag;
        next_irqStatus = irqStatus;
        next_irqMask   = irqMask;
        // [RULE_12] protected writes only unlocked
        if (ctrlWr && regUnlocked)
        begin
            next_armBit   = wb_dat_i[`PWC_BIT_PD_ARM];
            next_wakeIen  = wb_dat_i[`PWC_BIT_WAKE_IEN];
            next_delayEn  = wb_dat_i[`PWC_BIT_DLY_EN];
            next_slowRcEn = wb_dat_i[`PWC_BIT_SLOW_RC_EN];
            next_fastRcEn = wb_dat_i[`PWC_BIT_FAST_RC_EN];
        end
        // rc48 enable sits in the second byte lane
        if (ctrlWr && regUnlocked && wb_sel_i[1])
            next_rc48En = wb_dat_i[`PWC_BIT_RC48_EN];
        // [RULE_05] write one clears flag
        if (ctrlWr && wb_dat_i[`PWC_BIT_WAKE_FLAG])
            next_wakeFlag = 1'b0;
        // status bits are write-one-to-clear
        if (statWr)
            next_irqStatus = irqStatus & ~wb_dat_i[1:0];
        // mask is a plain read-write word
        if (maskWr)
            next_irqMask = wb_dat_i[1:0];
        // [RULE_04] set wins over clear
        if (wakeNow)
        begin
            next_wakeFlag  = 1'b1;
            next_irqStatus[0] = 1'b1;
            // [RULE_13] auto-clear arm on wake
            next_armBit    = 1'b0;
        end
        // power-down entry event, set after the clear so it wins
        if (state == pwc_pkg::RUN && armBit && sleepRequest)
            next_irqStatus[1] = 1'b1;
    end

    // ************************************************************
    // bus answer next values
    // ************************************************************
    always_comb
    begin
        next_ack    = busReq && mapped;
        next_err    = busReq && !mapped;
        next_rdData = 32'h0000_0000;
        if (busReq && !wb_we_i)
        begin
            if (wb_adr_i == `PWC_OFS_CTRL)
            begin
                next_rdData[`PWC_BIT_PD_ARM]     = armBit;
                next_rdData[`PWC_BIT_WAKE_FLAG]  = wakeFlag;
                next_rdData[`PWC_BIT_WAKE_IEN]   = wakeIen;
                next_rdData[`PWC_BIT_DLY_EN]     = delayEn;
                next_rdData[`PWC_BIT_SLOW_RC_EN] = slowRcEn;
                next_rdData[`PWC_BIT_FAST_RC_EN] = fastRcEn;
                next_rdData[`PWC_BIT_RC48_EN]    = rc48En;
            end
            else if (wb_adr_i == `PWC_OFS_STATUS)
            begin
                next_rdData[1:0] = irqStatus;
            end
            else if (wb_adr_i == `PWC_OFS_MASK)
            begin
                next_rdData[1:0] = irqMask;
            end
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            state      <= pwc_pkg::RUN;
            delayCount <= 13'h0000;
            armBit     <= RST_CTRL[`PWC_BIT_PD_ARM];
            wakeFlag   <= RST_CTRL[`PWC_BIT_WAKE_FLAG];
            wakeIen    <= RST_CTRL[`PWC_BIT_WAKE_IEN];
            delayEn    <= RST_CTRL[`PWC_BIT_DLY_EN];
            slowRcEn   <= RST_CTRL[`PWC_BIT_SLOW_RC_EN];
            fastRcEn   <= RST_CTRL[`PWC_BIT_FAST_RC_EN];
            rc48En     <= RST_CTRL[`PWC_BIT_RC48_EN];
            irqStatus  <= 2'h0;
            irqMask    <= `PWC_RST_MASK;
            ack        <= 1'b0;
            err        <= 1'b0;
            rdData     <= 32'h0000_0000;
        end
        else
        begin
            state      <= next_state;
            delayCount <= next_delayCount;
            armBit     <= next_armBit;
            wakeFlag   <= next_wakeFlag;
            wakeIen    <= next_wakeIen;
            delayEn    <= next_delayEn;
            slowRcEn   <= next_slowRcEn;
            fastRcEn   <= next_fastRcEn;
            rc48En     <= next_rc48En;
            irqStatus  <= next_irqStatus;
            irqMask    <= next_irqMask;
            ack        <= next_ack;
            err        <= next_err;
            rdData     <= next_rdData;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign wb_ack_o    = ack;
    assign wb_err_o    = err;
    assign wb_dat_o    = rdData;
    assign inPowerDown = (state == pwc_pkg::POWER_DOWN);
    // [RULE_01] gate pll and sysclk
    assign pllRun      = (state != pwc_pkg::POWER_DOWN);
    assign sysClkRun   = (state == pwc_pkg::RUN);
    // [RULE_02] low-speed peripherals stay on
    assign periphClkRun = periphClkEnable & (periphLowSpeedSrc | {PERIPH_COUNT{!inPowerDown}});
    // [RULE_14] fast oscillators off
    assign hsCrystalRun = !inPowerDown;
    // [RULE_11] fast rc follows bit
    assign fastRcRun    = fastRcEn && !inPowerDown;
    assign rc48Run      = rc48En && !inPowerDown;
    // [RULE_10] slow rc follows bit
    assign slowRcRun    = slowRcEn;
    // [RULE_06] flag acts only when enabled
    // [RULE_07] interrupt from flag and enable
    assign wakeIrq      = wakeFlag && wakeIen;
    assign irq          = |(irqStatus & irqMask);

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_pd_clock_gate: assert property (inPowerDown |-> !sysClkRun && !pllRun) // [RULE_01]
        else $error("clock runs in power-down");
    a_periph_low_run: assert property ( // [RULE_02]
        inPowerDown |-> periphClkRun == (periphClkEnable & periphLowSpeedSrc))
        else $error("peripheral gating wrong");
    a_pd_entry: assert property ( // [RULE_03]
        state == pwc_pkg::RUN && armBit && sleepRequest |=> inPowerDown)
        else $error("no power-down entry");
    a_wake_sets_flag: assert property (wakeNow |=> wakeFlag) // [RULE_04]
        else $error("wake flag not set");
    a_flag_clear: assert property (ctrlWr && wb_dat_i[6] && !wakeNow |=> !wakeFlag) // [RULE_05]
        else $error("wake flag not cleared");
    a_flag_zero_keep: assert property ( // [RULE_05]
        wakeFlag && ctrlWr && !wb_dat_i[6] |=> wakeFlag)
        else $error("zero write cleared flag");
    a_irq_pair: assert property (wakeIrq == (wakeFlag && wakeIen)) // [RULE_07]
        else $error("wake irq mismatch");
    // 256 clocks low after the wake edge, released on the very next one
    a_fast_delay: assert property ( // [RULE_08]
        wakeNow && delayEn && sysClkSource == 2'h1 |=> !sysClkRun [*8] ##248 !sysClkRun ##1 sysClkRun)
        else $error("fast rc delay wrong");
    a_no_delay: assert property (wakeNow && !delayEn |=> sysClkRun) // [RULE_09]
        else $error("delay inserted while disabled");
    a_lock_hold: assert property ( // [RULE_12]
        ctrlWr && !regUnlocked && !wakeNow |=> $stable(delayEn) && $stable(fastRcEn))
        else $error("locked write took effect");
    a_arm_clear: assert property (wakeNow |=> !armBit) // [RULE_13]
        else $error("arm not cleared");
    a_osc_off: assert property ( // [RULE_14]
        inPowerDown |-> !hsCrystalRun && !fastRcRun && !rc48Run)
        else $error("oscillator on in power-down");

    c_pd_entry: cover property (state == pwc_pkg::RUN ##1 inPowerDown);
    c_wake_delay: cover property (state == pwc_pkg::WAKE_DELAY ##1 state == pwc_pkg::RUN);
    c_wake_irq: cover property (wakeIrq);
    c_set_clear: cover property (wakeNow && ctrlWr && wb_dat_i[6]);

endmodule : pwc_powerdown_ctrl

// >>> pwc_consts.svh
/*
 * register offsets, bit positions, reset values and delay counts of the
 * power-down and wake-up clock control block.
 * assumes inclusion by bare name from the design file and the bench.
 */
`ifndef PWC_CONSTS_SVH
`define PWC_CONSTS_SVH

// ************************************************************
// register offsets (byte addresses)
// ************************************************************
`define PWC_OFS_CTRL        4'h0
`define PWC_OFS_STATUS      4'h4
`define PWC_OFS_MASK        4'h8

// ************************************************************
// control register fields
// ************************************************************
`define PWC_BIT_FAST_RC_EN  2
`define PWC_BIT_SLOW_RC_EN  3
`define PWC_BIT_DLY_EN      4
`define PWC_BIT_WAKE_IEN    5
`define PWC_BIT_WAKE_FLAG   6
`define PWC_BIT_PD_ARM      7
`define PWC_BIT_RC48_EN     13

// ************************************************************
// reset values
// ************************************************************
`define PWC_RST_CTRL        32'h0000_2014
`define PWC_RST_MASK        2'h0

// ************************************************************
// wake-up stabilisation delays in clocks
// ************************************************************
`define PWC_DLY_HS_XTAL     13'h1000
`define PWC_DLY_FAST_RC     13'h0100
`define PWC_DLY_RC48        13'h0200

`endif

// >>> pwc_pkg.sv
/*
 * types of the power-down and wake-up clock control block.
 * assumes nothing of its surroundings.
 */
package pwc_pkg;

    // ************************************************************
    // types
    // ************************************************************
    // power state of the chip
    typedef enum logic [1:0] {
        RUN,
        POWER_DOWN,
        WAKE_DELAY
    } pwc_state_e;

    // system clock source, drives the wake-up delay length
    typedef enum logic [1:0] {
        SRC_HS_CRYSTAL = 2'h0,
        SRC_FAST_RC    = 2'h1,
        SRC_RC48       = 2'h2,
        SRC_OTHER      = 2'h3
    } pwc_src_e;

endpackage : pwc_pkg

// >>> pwc_core_model.sv
/*
 * model of the core sleep logic, the wake sources and the register lock.
 * assumes the bench drives its commands by non-blocking assignment on clk.
 */
module pwc_core_model
(
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic sleepCmd,     // core executes its sleep instruction
    input  wire logic wakeCmd,      // a wake source fires
    input  wire logic unlockCmd,    // software opened the lock sequence
    output logic      sleepRequest,
    output logic      wakeEvent,
    output logic      regUnlocked
);
    timeunit 1ns;
    timeprecision 1ps;

    // ************************************************************
    // next values
    // ************************************************************
    logic next_sleepRequest;
    logic next_wakeEvent;
    logic next_regUnlocked;

    // the core stays asleep until a wake source fires
    always_comb
    begin
        next_sleepRequest = sleepCmd & ~wakeCmd;
        next_wakeEvent    = wakeCmd;
        next_regUnlocked  = unlockCmd;
    end

    // registered so every change lands just after an edge
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            sleepRequest <= 1'b0;
            wakeEvent    <= 1'b0;
            regUnlocked  <= 1'b0;
        end
        else
        begin
            sleepRequest <= next_sleepRequest;
            wakeEvent    <= next_wakeEvent;
            regUnlocked  <= next_regUnlocked;
        end
    end
endmodule : pwc_core_model

// >>> tb_powerdown_wakeup_clock_ctrl.sv
/*
 * self-checking bench of the power-down and wake-up clock control.
 * assumes the design answers a wishbone request one cycle after taking it.
 */
`include "pwc_consts.svh"

module tb_powerdown_wakeup_clock_ctrl;
    timeunit 1ns;
    timeprecision 1ps;

    // ************************************************************
    // signals
    // ************************************************************
    logic        clk, reset_n, cyc, stb, we, ack, err;
    logic [3:0]  adr, sel;
    logic [31:0] wdat, rdat;
    logic        sleepCmd, wakeCmd, unlockCmd, sleepRequest, wakeEvent, regUnlocked;
    logic [1:0]  srcSel;
    logic [3:0]  lsSrc, pEn, periphClkRun;
    logic        sysClkRun, pllRun, hsCrystalRun, fastRcRun, rc48Run, slowRcRun;
    logic        inPowerDown, wakeIrq, irq;
    int          errTotal = 0;
    int          checked  = 0;
    // hold-off lengths for hs crystal, fast rc and rc48 sources
    localparam int DLYS [3] = '{4096, 256, 512};

    pwc_powerdown_ctrl #(.PERIPH_COUNT(4)) DUT (
        .clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .wb_err_o(err), .sleepRequest(sleepRequest),
        .wakeEvent(wakeEvent), .regUnlocked(regUnlocked), .sysClkSource(srcSel),
        .periphLowSpeedSrc(lsSrc), .periphClkEnable(pEn), .sysClkRun(sysClkRun),
        .pllRun(pllRun), .periphClkRun(periphClkRun), .hsCrystalRun(hsCrystalRun),
        .fastRcRun(fastRcRun), .rc48Run(rc48Run), .slowRcRun(slowRcRun),
        .inPowerDown(inPowerDown), .wakeIrq(wakeIrq), .irq(irq));

    pwc_core_model CORE (
        .clk(clk), .reset_n(reset_n), .sleepCmd(sleepCmd), .wakeCmd(wakeCmd),
        .unlockCmd(unlockCmd), .sleepRequest(sleepRequest), .wakeEvent(wakeEvent),
        .regUnlocked(regUnlocked));

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic results;
        $display("checked %0d errors %0d", checked, errTotal);
        if (errTotal == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            errTotal++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // one classic cycle; the request holds until ack or err is sampled high
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        sel  <= 4'hf;
        do
        begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 100);
        rd = rdat;
        er = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        sel <= 4'h0;
        if (n >= 100)
            chk("busAnswer", 32'h1, 32'h0);
    endtask : bus

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        er;
        bus(1'b1, a, d, rd, er);
    endtask : wr

    task automatic rdchk(input string name, input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic        er;
        bus(1'b0, a, 32'h0, rd, er);
        chk(name, exp, rd);
    endtask : rdchk

    // sleep, check the gated outputs, wake, and measure the clock hold-off
    task automatic powerCycle(input logic [1:0] src, input int dly);
        int n;
        @(posedge clk);
        srcSel   <= src;
        sleepCmd <= 1'b1;
        n = 0;
        while (inPowerDown !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        chk("inPowerDown", 32'h1, inPowerDown);
        chk("sysClkRun", 32'h0, sysClkRun);
        chk("pllRun", 32'h0, pllRun);
        chk("periphClkRun", 32'h5, periphClkRun);
        chk("fastOsc", 32'h0, {hsCrystalRun, fastRcRun, rc48Run});
        wakeCmd <= 1'b1;
        @(posedge clk);
        wakeCmd  <= 1'b0;
        sleepCmd <= 1'b0;
        n = 1;
        while (sysClkRun !== 1'b1 && n < 5000)
        begin
            @(posedge clk);
            n++;
        end
        // model register, state register and the sampling edge add three
        chk("wakeDelay", 32'(dly + 3), 32'(n));
    endtask : powerCycle

    // ************************************************************
    // clock, watchdog, sequence
    // ************************************************************
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // the tests need some 5000 cycles; six times that means a hang
    initial
    begin
        repeat (30000) @(posedge clk);
        errTotal++;
        results();
    end

    initial
    begin
        logic [31:0] rd;
        logic        er;
        reset_n = 1'b0;
        sel = 4'h0;
        cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 4'h0; wdat = 32'h0;
        sleepCmd = 1'b0; wakeCmd = 1'b0; unlockCmd = 1'b0;
        srcSel = 2'h1; lsSrc = 4'h5; pEn = 4'hf;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        rdchk("ctrlReset", `PWC_OFS_CTRL, 32'h0000_2014);
        chk("slowRcRun", 32'h0, slowRcRun);
        wr(`PWC_OFS_CTRL, 32'h0000_00a8);
        rdchk("ctrlLocked", `PWC_OFS_CTRL, 32'h0000_2014);
        unlockCmd <= 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            wr(`PWC_OFS_CTRL, 32'h0000_20bc);
            chk("slowRcOn", 32'h1, slowRcRun);
            powerCycle(2'(i), DLYS[i]);
            chk("wakeIrq", 32'h1, wakeIrq);
            rdchk("ctrlWoke", `PWC_OFS_CTRL, 32'h0000_207c);
            wr(`PWC_OFS_CTRL, 32'h0000_203c);
            rdchk("flagKeep", `PWC_OFS_CTRL, 32'h0000_207c);
        end
        // a locked write still clears the flag but moves nothing else
        unlockCmd <= 1'b0;
        wr(`PWC_OFS_CTRL, 32'h0000_0040);
        rdchk("flagClr", `PWC_OFS_CTRL, 32'h0000_203c);
        chk("wakeIrqOff", 32'h0, wakeIrq);
        rdchk("status", `PWC_OFS_STATUS, 32'h0000_0003);
        chk("irqMasked", 32'h0, irq);
        wr(`PWC_OFS_MASK, 32'h0000_0001);
        chk("irqOn", 32'h1, irq);
        wr(`PWC_OFS_STATUS, 32'h0000_0003);
        chk("irqClr", 32'h0, irq);
        rdchk("statusClr", `PWC_OFS_STATUS, 32'h0000_0000);
        bus(1'b0, 4'hc, 32'h0, rd, er);
        chk("unmappedErr", 32'h1, er);
        // no delay, no wake interrupt, fast rc switched off
        unlockCmd <= 1'b1;
        wr(`PWC_OFS_CTRL, 32'h0000_2080);
        chk("fastRcOff", 32'h0, fastRcRun);
        powerCycle(2'h3, 0);
        chk("wakeIrqDis", 32'h0, wakeIrq);
        // arm was cleared by the wake, so sleep alone must not power down
        @(posedge clk);
        sleepCmd <= 1'b1;
        repeat (6) @(posedge clk);
        chk("noPowerDown", 32'h0, inPowerDown);
        sleepCmd <= 1'b0;
        results();
    end
endmodule : tb_powerdown_wakeup_clock_ctrl
